// ===== rtl/pcs_sequencer.sv
// Program counter, phase generator and return stack of the core.
// Assumes the decoder presents op_in and its operands during T4 of an
// executing cycle, and program memory returns instr_in by T4.
`include "pcs_regs.svh"

module pcs_sequencer #(
  parameter int INSTR_W = 15,
  parameter int DEPTH   = `PCS_STACK_DEPTH
) (
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     srst_in,
  // Program memory fetch port
  output logic                          fetch_req_out,
  output logic [`PCS_PC_W-1:0]          fetch_addr_out,
  input  wire logic [INSTR_W-1:0]       instr_in,
  // Decoder side
  output logic [3:0]                    clock_phases_out,
  output logic [INSTR_W-1:0]            instr_out,
  output logic                          exec_valid_out,
  output logic [`PCS_PAGE_W-1:0]        pc_low_byte_out,
  input  wire pcs_pkg::pcs_op_t         op_in,
  input  wire logic [`PCS_PC_W-1:0]     jump_target_in,
  input  wire logic [`PCS_PAGE_W-1:0]   pc_low_byte_wdata_in,
  // Interrupt request logic
  input  wire logic [`PCS_IRQ_NUM-1:0]  irq_req_in,
  output logic                          irq_ack_out,
  output logic [`PCS_IRQ_NUM-1:0]       irq_ack_src_out,
  output logic                          stack_full_out
);
  import pcs_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  // Lowest-numbered pending source wins
  function automatic logic [`PCS_IRQ_NUM-1:0] pick_irq(
    input logic [`PCS_IRQ_NUM-1:0] req
  );
    logic [`PCS_IRQ_NUM-1:0] one;
    one = '0;
    for (int i = `PCS_IRQ_NUM - 1; i >= 0; i--) begin
      if (req[i]) begin
        one = '0;
        one[i] = 1'b1;
      end
    end
    return one;
  endfunction : pick_irq

  // Fixed entry address of a one-hot source
  function automatic logic [`PCS_PC_W-1:0] irq_vector(
    input logic [`PCS_IRQ_NUM-1:0] one
  );
    logic [`PCS_PC_W-1:0] vec;
    vec = `PCS_RESET_PC;
    unique case (1'b1)
      one[0]:  vec = `PCS_VEC_CMP;
      one[1]:  vec = `PCS_VEC_EXT0;
      one[2]:  vec = `PCS_VEC_MULTI;
      one[3]:  vec = `PCS_VEC_PWM;
      one[4]:  vec = `PCS_VEC_TMR0;
      one[5]:  vec = `PCS_VEC_TMR1;
      default: vec = `PCS_RESET_PC;
    endcase
    return vec;
  endfunction : irq_vector

  pcs_stack_if #(.ADDR_W(PTR_W), .DATA_W(`PCS_PC_W)) stk ();

  pcs_stack_mem #(.DEPTH(DEPTH)) u_stack (
    .sys_clk_in (sys_clk_in),
    .stk        (stk)
  );

  pcs_phase_t            phase;
  pcs_phase_t            next_phase;
  logic [`PCS_PC_W-1:0]  pc;
  logic [`PCS_PC_W-1:0]  next_pc;
  logic [CNT_W-1:0]      stack_index;
  logic [CNT_W-1:0]      next_stack_index;
  logic                  prefetch_ok;
  logic                  next_prefetch_ok;
  logic [3:0]            next_clock_phases;
  logic                  next_fetch_req;
  logic [`PCS_PC_W-1:0]  next_fetch_addr;
  logic [INSTR_W-1:0]    next_instr;
  logic                  next_exec_valid;
  logic [`PCS_PAGE_W-1:0] next_pc_low_byte;
  logic                  next_irq_ack;
  logic [`PCS_IRQ_NUM-1:0] next_irq_ack_src;
  logic                  next_stack_full;
  logic                  act;
  logic                  irq_take;
  logic [`PCS_IRQ_NUM-1:0] irq_one;
  logic                  branch;
  logic [`PCS_PC_W-1:0]  branch_addr;

  // Stack write and read addresses
  always_comb begin
    act       = (phase == PCS_PH_T4) && exec_valid_out;
    irq_one   = pick_irq(irq_req_in);
    irq_take  = (phase == PCS_PH_T4) && (irq_req_in != '0) &&
                (!act || op_in == PCS_OP_NONE || op_in == PCS_OP_PCL_WR ||
                 op_in == PCS_OP_SKIP) &&
                (stack_index != CNT_FULL) &&
                !(act && op_in inside {PCS_OP_SKIP, PCS_OP_PCL_WR}); // RL13
    stk.wr_en   = (phase == PCS_PH_T4) &&
                  ((act && op_in == PCS_OP_CALL) || irq_take); // RL11
    stk.wr_addr = stack_index[PTR_W-1:0];                      // RL14
    stk.wr_data = fetch_addr_out;
    stk.rd_addr = PTR_W'(stack_index - CNT_ONE);
  end

  // Next values of phase, counter, stack index and outputs
  always_comb begin
    next_phase        = phase;
    next_pc           = pc;
    next_stack_index  = stack_index;
    next_prefetch_ok  = prefetch_ok;
    next_fetch_req    = 1'b0;
    next_fetch_addr   = fetch_addr_out;
    next_instr        = instr_out;
    next_exec_valid   = exec_valid_out;
    next_pc_low_byte  = pc_low_byte_out;
    next_irq_ack      = 1'b0;
    next_irq_ack_src  = irq_ack_src_out;
    branch            = 1'b0;
    branch_addr       = pc;
    unique case (phase)
      PCS_PH_T1: next_phase = PCS_PH_T2; // RL1
      PCS_PH_T2: next_phase = PCS_PH_T3;
      PCS_PH_T3: next_phase = PCS_PH_T4;
      PCS_PH_T4: next_phase = PCS_PH_T1;
    endcase
    next_clock_phases = 4'h0;
    next_clock_phases[next_phase] = 1'b1;
    if (phase == PCS_PH_T4) begin
      // Fetch next instruction and advance the counter
      next_fetch_req   = 1'b1;                                 // RL2
      next_fetch_addr  = pc;                                   // RL3
      next_pc_low_byte = fetch_addr_out[`PCS_PAGE_W-1:0];      // RL5
      next_pc          = `PCS_PC_W'(pc + `PCS_PC_W'(1));       // RL4
      next_instr       = instr_in;
      next_exec_valid  = prefetch_ok;
      next_prefetch_ok = 1'b1;
      if (act) begin
        unique case (op_in)
          PCS_OP_NONE: begin
          end
          PCS_OP_SKIP: begin
            next_exec_valid = 1'b0;                            // RL8
          end
          PCS_OP_PCL_WR: begin
            branch      = 1'b1;                                // RL7
            branch_addr = {fetch_addr_out[`PCS_PC_W-1:`PCS_PAGE_W],
                           pc_low_byte_wdata_in};              // RL6
          end
          PCS_OP_JUMP: begin
            branch      = 1'b1;                                // RL3
            branch_addr = jump_target_in;                      // RL9
          end
          PCS_OP_CALL: begin
            branch      = 1'b1;
            branch_addr = jump_target_in;                      // RL9
            if (stack_index != CNT_FULL) begin
              next_stack_index = CNT_W'(stack_index + CNT_ONE);
            end                                                // RL14
          end
          PCS_OP_RET, PCS_OP_RETURN_INTERRUPT: begin
            branch           = 1'b1;
            branch_addr      = stk.rd_data;                    // RL11
            next_stack_index = CNT_W'(stack_index - CNT_ONE);
          end
          default: begin
          end
        endcase
      end
      if (irq_take) begin
        branch           = 1'b1;
        branch_addr      = irq_vector(irq_one);                // RL15
        next_stack_index = CNT_W'(stack_index + CNT_ONE);
        next_irq_ack     = 1'b1;
        next_irq_ack_src = irq_one;
      end
      // Fetch the target now; the discarded prefetch is the dummy
      if (branch) begin
        next_fetch_addr = branch_addr;                         // RL9
        next_pc         = `PCS_PC_W'(branch_addr + `PCS_PC_W'(1));
        next_exec_valid = 1'b0;                                // RL17
      end
    end
    next_stack_full = (next_stack_index == CNT_FULL);
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      phase            <= PCS_PH_T4;
      pc               <= `PCS_RESET_PC;                       // RL16
      stack_index      <= '0;                                  // RL12
      prefetch_ok      <= 1'b0;
      clock_phases_out <= 4'h0;
      fetch_req_out    <= 1'b0;
      fetch_addr_out   <= `PCS_RESET_PC;
      instr_out        <= '0;
      exec_valid_out   <= 1'b0;
      pc_low_byte_out  <= '0;
      irq_ack_out      <= 1'b0;
      irq_ack_src_out  <= '0;
      stack_full_out   <= 1'b0;
    end else begin
      phase            <= next_phase;
      pc               <= next_pc;
      stack_index      <= next_stack_index;
      prefetch_ok      <= next_prefetch_ok;
      clock_phases_out <= next_clock_phases;
      fetch_req_out    <= next_fetch_req;
      fetch_addr_out   <= next_fetch_addr;
      instr_out        <= next_instr;
      exec_valid_out   <= next_exec_valid;
      pc_low_byte_out  <= next_pc_low_byte;
      irq_ack_out      <= next_irq_ack;
      irq_ack_src_out  <= next_irq_ack_src;
      stack_full_out   <= next_stack_full;
    end
  end
endmodule : pcs_sequencer

// ===== rtl/pcs_regs.svh
// Constants for the program counter and stack sequencer.
// Assumes one system clock; included by bare name after the package.
// Operation
// [RL1] Four non-overlapping phases form one instruction cycle
// [RL2] Counter advances at T1; T2-T4 decode and execute
// [RL3] Fetch overlaps execute; branches take two cycles
// [RL4] Counter increments unless control transfers elsewhere
// [RL5] Only low counter byte is software accessible
// [RL6] Low byte write keeps upper bits, same page
// [RL7] Low byte write inserts one dummy cycle
// [RL8] Taken skip discards prefetch, counter plus two
// [RL9] Jump, call, interrupt, reset load target directly
// [RL10] Eight-level stack, invisible to software
// [RL11] Call and interrupt push; returns restore twelve bits
// [RL12] Reset points stack index at top
// [RL13] Full stack withholds interrupt acknowledge until return
// [RL14] Call on full stack still executes, overflows
// [RL15] Acknowledge loads fixed vector per source
// [RL16] Reset clears counter, fetch starts at zero
// [RL17] Interrupt entry acts like a two-cycle call
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

`define PCS_PC_W        12
`define PCS_PAGE_W      8
`define PCS_RESET_PC    12'h000
`define PCS_STACK_DEPTH 8
`define PCS_IRQ_NUM     6
`define PCS_VEC_CMP     12'h004
`define PCS_VEC_EXT0    12'h008
`define PCS_VEC_MULTI   12'h00c
`define PCS_VEC_PWM     12'h010
`define PCS_VEC_TMR0    12'h014
`define PCS_VEC_TMR1    12'h018

`endif

// ===== rtl/pcs_pkg.sv
// Types for the program counter and stack sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_PH_T1,
    PCS_PH_T2,
    PCS_PH_T3,
    PCS_PH_T4
  } pcs_phase_t;

  typedef enum logic [2:0] {
    PCS_OP_NONE,
    PCS_OP_SKIP,
    PCS_OP_PCL_WR,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RET,
    PCS_OP_RETURN_INTERRUPT
  } pcs_op_t;

endpackage : pcs_pkg

// ===== rtl/pcs_stack_if.sv
// Connection between the sequencer and its return-address memory.
// Assumes both ends share sys_clk_in.
interface pcs_stack_if #(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 12
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
  modport mem   (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : pcs_stack_if

// ===== rtl/pcs_stack_mem.sv
// Return-address memory with registered read data.
// Assumes writes and reads come from the sequencer on the same clock.
module pcs_stack_mem #(
  parameter int DEPTH = 8
) (
  // Clock
  input wire logic    sys_clk_in,
  // Memory port
  pcs_stack_if.mem    stk
);
  logic [$bits(stk.wr_data)-1:0] mem [DEPTH];
  logic [$bits(stk.wr_data)-1:0] rd_q;

  always_ff @(posedge sys_clk_in) begin
    if (stk.wr_en) begin
      mem[stk.wr_addr] <= stk.wr_data; // RL10
    end
    rd_q <= mem[stk.rd_addr];
  end

  assign stk.rd_data = rd_q;
endmodule : pcs_stack_mem

// ===== sim/pcs_prog_mem.sv
// Program memory model for the fetch port.
// Assumes the fetch address stands for the whole instruction cycle.
module pcs_prog_mem (
  // Fetch port
  input  wire logic [11:0] fetch_addr_in,
  input  wire logic        t4_in,
  output logic      [14:0] instr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Word valid in T4 only, inverse pattern otherwise
  assign instr_out = t4_in ? {3'h5, fetch_addr_in ^ 12'h3c9}
                           : ~{3'h5, fetch_addr_in ^ 12'h3c9};
endmodule : pcs_prog_mem

// ===== sim/pcs_seq_props.sv
// Checker on the sequencer ports.
// Assumes the bind below attaches it to every sequencer.
`include "pcs_regs.svh"
module pcs_seq_props (
  // Clock and reset
  input wire logic                    sys_clk_in,
  input wire logic                    srst_in,
  // Outputs watched
  input wire logic                    fetch_req_out,
  input wire logic [`PCS_PC_W-1:0]    fetch_addr_out,
  input wire logic [3:0]              clock_phases_out,
  input wire logic                    exec_valid_out,
  input wire logic                    irq_ack_out,
  input wire logic [`PCS_IRQ_NUM-1:0] irq_ack_src_out,
  input wire logic                    stack_full_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence holds3;
    ($stable(fetch_addr_out) && $stable(exec_valid_out)) [*3];
  endsequence
  phase_onehot_a: assert property (
    !$past(srst_in) |-> $onehot(clock_phases_out)) else $error("bad phase");
  phase_rotate_a: assert property (
    clock_phases_out[3] |=> clock_phases_out[0]) else $error("no wrap");
  fetch_t1_a: assert property (
    !$past(srst_in) |-> fetch_req_out == clock_phases_out[0])
    else $error("fetch not at T1");
  addr_stands_a: assert property (
    clock_phases_out[0] |=> holds3) else $error("fetch moved");
  ack_vector_a: assert property (
    irq_ack_out |-> clock_phases_out[0] && !exec_valid_out &&
    fetch_addr_out[11:5] == 7'h00 && fetch_addr_out[1:0] == 2'h0 &&
    irq_ack_src_out == (6'h01 << (fetch_addr_out[4:2] - 3'h1)))
    else $error("bad vector");
  full_hold_a: assert property (
    clock_phases_out[3] && stack_full_out |=> !irq_ack_out)
    else $error("ack while full");
  ack_pulse_a: assert property (
    irq_ack_out |=> !irq_ack_out [*3] ##1 (exec_valid_out != irq_ack_out))
    else $error("bad entry");
  reset_start_a: assert property (
    $fell(srst_in) |=> fetch_addr_out == 12'h000 &&
    clock_phases_out == 4'h1 && !exec_valid_out) else $error("bad start");
endmodule : pcs_seq_props

bind pcs_sequencer pcs_seq_props u_props (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in),
  .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out),
  .clock_phases_out(clock_phases_out), .exec_valid_out(exec_valid_out),
  .irq_ack_out(irq_ack_out), .irq_ack_src_out(irq_ack_src_out),
  .stack_full_out(stack_full_out));

// ===== sim/tb_pc_stack_sequencer.sv
// Bench for the sequencer: random op stream against a queue model.
// Assumes the memory model answers in T4.
`include "pcs_regs.svh"
module tb_pc_stack_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic [11:0] faddr;
  logic [14:0] imem;
  logic [3:0]  ph;
  logic [14:0] instr;
  logic        ev;
  logic [7:0]  plo;
  pcs_op_t     op = PCS_OP_NONE;
  logic [11:0] tgt = 12'h000;
  logic [7:0]  wd = 8'h00;
  logic [5:0]  irq = 6'h00;
  logic        ack;
  logic [5:0]  src;
  logic        full;
  logic [11:0] f;
  logic        v;
  logic [11:0] stk [$];
  logic [11:0] vec [6] = '{`PCS_VEC_CMP, `PCS_VEC_EXT0, `PCS_VEC_MULTI,
                           `PCS_VEC_PWM, `PCS_VEC_TMR0, `PCS_VEC_TMR1};
  int          err_total = 0;
  int          n_checks = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  pcs_sequencer #(.INSTR_W(15), .DEPTH(`PCS_STACK_DEPTH)) dut_u (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .fetch_req_out(),
    .fetch_addr_out(faddr), .instr_in(imem), .clock_phases_out(ph),
    .instr_out(instr), .exec_valid_out(ev), .pc_low_byte_out(plo),
    .op_in(op), .jump_target_in(tgt), .pc_low_byte_wdata_in(wd),
    .irq_req_in(irq), .irq_ack_out(ack), .irq_ack_src_out(src),
    .stack_full_out(full));
  pcs_prog_mem mem_u (.fetch_addr_in(faddr), .t4_in(ph[3]),
                      .instr_out(imem));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic do_reset;
    srst_in = 1'b1;
    repeat (16) @(negedge sys_clk_in);
    srst_in = 1'b0;
    stk.delete();
    f = 12'h000;
    v = 1'b0;
    irq = 6'h00;
    @(negedge sys_clk_in);
    chk(ph, 4'h1);
    chk(faddr, 12'h000);
    chk({full, ev}, 2'h0);
  endtask : do_reset

  // Mode 0 random, 1 call, 2 return, 3 no op
  task automatic step(input int mode);
    pcs_op_t     o;
    logic [11:0] nf;
    logic        nv;
    logic        ak;
    int          k;
    @(negedge sys_clk_in iff ph[3]);
    o = mode == 1 ? PCS_OP_CALL : mode == 2 ? PCS_OP_RET :
        mode == 3 ? PCS_OP_NONE : pcs_op_t'($urandom % 7);
    if (mode == 0 && irq == 6'h00 && $urandom % 6 == 0) irq = 6'($urandom);
    if (o == PCS_OP_CALL && stk.size() >= 8 && mode == 0) o = PCS_OP_NONE;
    if (o inside {PCS_OP_RET, PCS_OP_RETURN_INTERRUPT} && stk.size() == 0)
      o = PCS_OP_NONE;
    op = o;
    tgt = 12'($urandom);
    wd = 8'($urandom);
    nf = f + 12'h001;
    nv = 1'b0;
    ak = 1'b0;
    k = 0;
    if (v && o != PCS_OP_NONE) begin
      case (o)
        PCS_OP_PCL_WR: nf = {f[11:8], wd};
        PCS_OP_JUMP, PCS_OP_CALL: nf = tgt;
        PCS_OP_RET, PCS_OP_RETURN_INTERRUPT: nf = stk.pop_back();
        default: ;
      endcase
      if (o == PCS_OP_CALL) stk.push_back(f);
    end else if (irq != 6'h00 && stk.size() < 8) begin
      while (!irq[k]) k++;
      stk.push_back(f);
      nf = vec[k];
      ak = 1'b1;
    end else nv = 1'b1;
    @(negedge sys_clk_in);
    chk(ph, 4'h1);
    chk(faddr, nf);
    chk(ev, nv);
    chk(ack, ak);
    if (ak) chk(src, 6'h01 << k);
    chk(full, stk.size() >= 8);
    if (nv) chk(instr, {3'h5, f ^ 12'h3c9});
    if (nv) chk(plo, f[7:0]);
    if (ak) irq = 6'h00;
    f = nf;
    v = nv;
  endtask : step

  initial begin
    void'($urandom(35034));
    do_reset();
    repeat (300) step(0);
    while (stk.size() < 8) step(1);
    irq = 6'h30;
    repeat (4) step(3);
    repeat (3) step(2);
    while (stk.size() < 9) step(1);
    do_reset();
    repeat (100) step(0);
    end_sim();
  end

  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : tb_pc_stack_sequencer
